// *** verilog/cbt_regs.svh ***
// Register map, field positions and reset values of the CAN bit timing
// and identifier filter block.
// Assumes inclusion by bare name from every design file that needs it.
//
// Functional notes
// - Timing registers hold prescale, jump, segments, sampling
// - Synchronisation segment always lasts one time slice
// - Each segment lasts field value plus one
// - Bit period is four plus segment fields
// - Time slice is prescale plus one clocks
// - Segment fields three bits, prescale up to 63
// - Sample at end of first phase segment
// - Sampling select picks single or majority-of-three
// - Clock mode one selects doubled 20 MHz clock
// - Rejected identifiers are never forwarded
// - Mask one bits must match code bits
// - All-zero mask accepts every message
// - Standard compares 11 bits, extended 29
`ifndef CBT_REGS_SVH
`define CBT_REGS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CBT_ADDR_PRESCALE 8'h00
`define CBT_ADDR_JUMP_PROP 8'h04
`define CBT_ADDR_PHASE_SMP 8'h08
`define CBT_ADDR_CLK_MODE 8'h0C
`define CBT_ADDR_MATCH 8'h10
`define CBT_ADDR_MASK 8'h14
`define CBT_ADDR_STATUS 8'h18

// ****************************************************************
// Field positions and writable bit masks
// ****************************************************************
`define CBT_PRESCALE_MASK 8'h7E
`define CBT_JUMP_PROP_MASK 8'h6E
`define CBT_PHASE_SMP_MASK 8'h7F
`define CBT_BRP_MSB 6
`define CBT_BRP_LSB 1
`define CBT_SJW_MSB 6
`define CBT_SJW_LSB 5
`define CBT_PRS_MSB 3
`define CBT_PRS_LSB 1
`define CBT_PHASE_SEGMENT_SECOND_MSB 6
`define CBT_PHASE_SEGMENT_SECOND_LSB 4
`define CBT_PHASE_SEGMENT_FIRST_MSB 3
`define CBT_PHASE_SEGMENT_FIRST_LSB 1
`define CBT_SMP_BIT 0
`define CBT_CLK_MODE_BIT 0
`define CBT_STD_ID_BITS 11

// ****************************************************************
// Reset values
// ****************************************************************
`define CBT_RST_TIMING 8'h00
`define CBT_RST_ID 29'h0000000
`define CBT_SLICE_ZERO 6'h00
`define CBT_SEG_ZERO 3'h0

`endif

// *** verilog/cbt_pkg.sv ***
// Types shared by the CAN bit timing and identifier filter block.
// Assumes the constants of cbt_regs.svh for all numeric values.
package cbt_pkg;

  // ****************************************************************
  // Bit period segments
  // ****************************************************************
  typedef enum logic [3:0] {
    CBT_SEG_SYNC = 4'b0001,
    CBT_SEG_PROP = 4'b0010,
    CBT_SEG_PH1 = 4'b0100,
    CBT_SEG_PH2 = 4'b1000
  } cbt_seg_t;

  // ****************************************************************
  // State of the bus sampler
  // ****************************************************************
  typedef struct packed {
    logic sync1;
    logic [2:0] hist;
  } cbt_smp_state_t;

  // ****************************************************************
  // State of the top module
  // ****************************************************************
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] prescale;
    logic [7:0] jump_prop;
    logic [7:0] phase_smp;
    logic clk_mode;
    logic [28:0] match;
    logic [28:0] mask;
    logic [5:0] slice_cnt;
    logic [2:0] seg_cnt;
    cbt_seg_t seg;
    logic slice_tick;
    logic bit_start;
    logic sample_pulse;
    logic bit_value;
    logic fwd_valid;
    logic [28:0] fwd_id;
    logic fwd_ext;
    logic drop;
    logic last_accept;
  } cbt_state_t;

endpackage

// *** verilog/cbt_sampler.sv ***
// Bus pin synchroniser with three-sample majority vote.
// Assumes the bus pin is asynchronous to mclk_i.
`timescale 1ns/1ps
`include "cbt_regs.svh"

module cbt_sampler (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Bus pin
  input wire logic rx_pin_i,
  // Sampled levels
  output logic rx_level_o,
  output logic rx_vote_o
);

  cbt_pkg::cbt_smp_state_t s;
  cbt_pkg::cbt_smp_state_t next_s;

  // Majority of three samples
  function automatic logic cbt_major(input logic [2:0] v);
    cbt_major = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Two-stage synchroniser, then a history one clock apart
  always_comb begin
    next_s = s;
    next_s.sync1 = rx_pin_i;
    next_s.hist = {s.hist[1:0], s.sync1};
  end

  // State register; bus idles recessive
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign rx_level_o = s.hist[0];
  assign rx_vote_o = cbt_major(s.hist);

endmodule

// *** verilog/cbt_id_filter.sv ***
// Acceptance check of a received identifier against code and mask.
// Assumes identifier, code and mask are stable in the same clock.
`timescale 1ns/1ps
`include "cbt_regs.svh"

module cbt_id_filter (
  // Received identifier
  input wire logic [28:0] id_i,
  input wire logic ext_i,
  // Filter settings
  input wire logic [28:0] match_i,
  input wire logic [28:0] mask_i,
  // Verdict
  output logic accept_o
);

  logic [28:0] diff;
  logic [28:0] width_mask;

  // Standard frames compare only the low identifier bits
  always_comb begin
    width_mask = ext_i ? '1 : ((29'h0000001 << `CBT_STD_ID_BITS) -
                               29'h0000001);
    diff = (id_i ^ match_i) & mask_i & width_mask;
  end

  // Zero mask leaves no bit to differ
  assign accept_o = (diff == '0);

endmodule

// *** verilog/cbt_bit_timing.sv ***
// Top of the CAN bit timing and identifier filter block: APB register
// file, time slice prescaler, bit segment sequencer and forward gate.
// Assumes APB master on mclk_i, bus pin asynchronous, received
// identifiers delivered on mclk_i by the frame logic.
`timescale 1ns/1ps
`include "cbt_regs.svh"

module cbt_bit_timing (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  // Bus pin
  input wire logic can_rx_i,
  // Bit timing events
  output logic slice_tick_o,
  output logic bit_start_o,
  output logic sample_pulse_o,
  output logic bit_value_o,
  output logic [1:0] resync_jump_width_o,
  output logic doubled_clock_mode_o,
  // Received identifier from frame logic
  input wire logic rx_id_valid_i,
  input wire logic [28:0] rx_id_i,
  input wire logic rx_ext_i,
  // Forward to host port
  output logic fwd_valid_o,
  output logic [28:0] fwd_id_o,
  output logic fwd_ext_o,
  output logic fwd_drop_o
);

  // Registered state and its next value
  cbt_pkg::cbt_state_t s;
  cbt_pkg::cbt_state_t next_s;

  // Pin levels and filter verdict from the sub-blocks
  logic rx_level;
  logic rx_vote;
  logic accept;

  // Timing fields decoded from the registers
  logic [5:0] baud_prescale;
  logic [2:0] prop_segment;
  logic [2:0] phase_segment_first;
  logic [2:0] phase_segment_second;
  logic triple_sample_select;

  // Slice end and bus access strobes
  logic slice_end;
  logic access;
  logic commit;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // Mapped address check
  function automatic logic cbt_hit(input logic [7:0] a);
    cbt_hit = (a == `CBT_ADDR_PRESCALE) || (a == `CBT_ADDR_JUMP_PROP) ||
              (a == `CBT_ADDR_PHASE_SMP) || (a == `CBT_ADDR_CLK_MODE) ||
              (a == `CBT_ADDR_MATCH) || (a == `CBT_ADDR_MASK) ||
              (a == `CBT_ADDR_STATUS);
  endfunction

  // Read data of one register word
  function automatic logic [31:0] cbt_read(input logic [7:0] a,
                                           input cbt_pkg::cbt_state_t st);
    cbt_read = '0;
    case (a)
      `CBT_ADDR_PRESCALE: begin
        cbt_read = {24'h000000, st.prescale};
      end
      `CBT_ADDR_JUMP_PROP: begin
        cbt_read = {24'h000000, st.jump_prop};
      end
      `CBT_ADDR_PHASE_SMP: begin
        cbt_read = {24'h000000, st.phase_smp};
      end
      `CBT_ADDR_CLK_MODE: begin
        cbt_read = {31'h00000000, st.clk_mode};
      end
      `CBT_ADDR_MATCH: begin
        cbt_read = {3'h0, st.match};
      end
      `CBT_ADDR_MASK: begin
        cbt_read = {3'h0, st.mask};
      end
      `CBT_ADDR_STATUS: begin
        cbt_read = {25'h0000000, st.last_accept, st.bit_value,
                    st.seg, 1'h0};
      end
      default: begin
        cbt_read = '0;
      end
    endcase
  endfunction

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************

  // Pin synchroniser and majority vote
  cbt_sampler u_sampler (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .rx_pin_i(can_rx_i),
    .rx_level_o(rx_level),
    .rx_vote_o(rx_vote)
  );

  // Identifier acceptance check
  cbt_id_filter u_filter (
    .id_i(rx_id_i),
    .ext_i(rx_ext_i),
    .match_i(s.match),
    .mask_i(s.mask),
    .accept_o(accept)
  );

  // ****************************************************************
  // Field extraction
  // ****************************************************************

  // Timing fields from the three timing registers
  // Unused bits were already dropped on write, so the cuts stay clean
  always_comb begin
    baud_prescale = s.prescale[`CBT_BRP_MSB:`CBT_BRP_LSB];
    prop_segment = s.jump_prop[`CBT_PRS_MSB:`CBT_PRS_LSB];
    phase_segment_first = s.phase_smp[`CBT_PHASE_SEGMENT_FIRST_MSB:`CBT_PHASE_SEGMENT_FIRST_LSB];
    phase_segment_second = s.phase_smp[`CBT_PHASE_SEGMENT_SECOND_MSB:`CBT_PHASE_SEGMENT_SECOND_LSB];
    triple_sample_select = s.phase_smp[`CBT_SMP_BIT];
    slice_end = (s.slice_cnt == baud_prescale);
    access = psel_i & penable_i;
    commit = access & s.pready & pwrite_i & cbt_hit(paddr_i);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Register file, sequencer and forward gate
  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.slice_tick = 1'b0;
    next_s.bit_start = 1'b0;
    next_s.sample_pulse = 1'b0;
    next_s.fwd_valid = 1'b0;
    next_s.drop = 1'b0;

    // APB answer one cycle into the access phase
    // The answer is registered, so every access phase lasts two cycles;
    // the write itself lands at the edge that sees pready high
    if (access && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !cbt_hit(paddr_i);
      next_s.prdata = pwrite_i ? 32'h00000000 : cbt_read(paddr_i, s);
    end

    // Writes take effect at the edge that completes the transfer
    if (commit) begin
      case (paddr_i)
        `CBT_ADDR_PRESCALE: begin
          next_s.prescale = pwdata_i[7:0] & `CBT_PRESCALE_MASK;
        end
        `CBT_ADDR_JUMP_PROP: begin
          next_s.jump_prop = pwdata_i[7:0] & `CBT_JUMP_PROP_MASK;
        end
        `CBT_ADDR_PHASE_SMP: begin
          next_s.phase_smp = pwdata_i[7:0] & `CBT_PHASE_SMP_MASK;
        end
        `CBT_ADDR_CLK_MODE: begin
          next_s.clk_mode = pwdata_i[`CBT_CLK_MODE_BIT];
        end
        `CBT_ADDR_MATCH: begin
          next_s.match = pwdata_i[28:0];
        end
        `CBT_ADDR_MASK: begin
          next_s.mask = pwdata_i[28:0];
        end
        default: begin
          next_s.match = s.match;
        end
      endcase
    end

    // Time slice prescaler
    // A prescale lowered below the running count lets the count wrap
    // once before the new slice length applies
    if (slice_end) begin
      next_s.slice_cnt = `CBT_SLICE_ZERO;
      next_s.slice_tick = 1'b1;
    end else begin
      next_s.slice_cnt = s.slice_cnt + 6'h01;
    end

    // Segment sequencer, one step per time slice
    // Sync always lasts one slice, the others field plus one slices,
    // so a bit never spans fewer than four slices
    if (slice_end) begin
      case (s.seg)
        cbt_pkg::CBT_SEG_SYNC: begin
          next_s.seg = cbt_pkg::CBT_SEG_PROP;
          next_s.seg_cnt = `CBT_SEG_ZERO;
        end
        cbt_pkg::CBT_SEG_PROP: begin
          if (s.seg_cnt == prop_segment) begin
            next_s.seg = cbt_pkg::CBT_SEG_PH1;
            next_s.seg_cnt = `CBT_SEG_ZERO;
          end else begin
            next_s.seg_cnt = s.seg_cnt + 3'h1;
          end
        end
        cbt_pkg::CBT_SEG_PH1: begin
          if (s.seg_cnt == phase_segment_first) begin
            next_s.seg = cbt_pkg::CBT_SEG_PH2;
            next_s.seg_cnt = `CBT_SEG_ZERO;
            next_s.sample_pulse = 1'b1;
            next_s.bit_value = triple_sample_select ? rx_vote :
                               rx_level;
          end else begin
            next_s.seg_cnt = s.seg_cnt + 3'h1;
          end
        end
        cbt_pkg::CBT_SEG_PH2: begin
          if (s.seg_cnt == phase_segment_second) begin
            next_s.seg = cbt_pkg::CBT_SEG_SYNC;
            next_s.seg_cnt = `CBT_SEG_ZERO;
            next_s.bit_start = 1'b1;
          end else begin
            next_s.seg_cnt = s.seg_cnt + 3'h1;
          end
        end
        default: begin
          next_s.seg = cbt_pkg::CBT_SEG_SYNC;
          next_s.seg_cnt = `CBT_SEG_ZERO;
        end
      endcase
    end

    // Forward only accepted identifiers
    // The held identifier changes only on an accepted message, so the
    // host side never sees a rejected one
    if (rx_id_valid_i) begin
      next_s.fwd_valid = accept;
      next_s.drop = !accept;
      next_s.last_accept = accept;
      if (accept) begin
        next_s.fwd_id = rx_id_i;
        next_s.fwd_ext = rx_ext_i;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // All state of the top module
  // Timing and filter settings clear on reset, so the sequencer starts
  // in sync with a one-clock slice and every message is accepted
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.prescale <= `CBT_RST_TIMING;
      s.jump_prop <= `CBT_RST_TIMING;
      s.phase_smp <= `CBT_RST_TIMING;
      s.match <= `CBT_RST_ID;
      s.mask <= `CBT_RST_ID;
      s.seg <= cbt_pkg::CBT_SEG_SYNC;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Every output straight from the state register
  // The jump width is stored and shown; no resynchronisation uses it
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign prdata_o = s.prdata;
  assign slice_tick_o = s.slice_tick;
  assign bit_start_o = s.bit_start;
  assign sample_pulse_o = s.sample_pulse;
  assign bit_value_o = s.bit_value;
  assign resync_jump_width_o = s.jump_prop[`CBT_SJW_MSB:`CBT_SJW_LSB];
  assign doubled_clock_mode_o = s.clk_mode;
  assign fwd_valid_o = s.fwd_valid;
  assign fwd_id_o = s.fwd_id;
  assign fwd_ext_o = s.fwd_ext;
  assign fwd_drop_o = s.drop;

endmodule

// *** tb/cbt_bit_timing_asserts.sv ***
// Checker of the bit timing and identifier filter block at its ports.
// Assumes it is bound to cbt_bit_timing, one clock domain.
`timescale 1ns/1ps
module cbt_bit_timing_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Register bus
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] prdata_o,
  // Bit timing
  input wire logic sample_pulse_o,
  input wire logic bit_start_o,
  input wire logic bit_value_o,
  input wire logic [1:0] resync_jump_width_o,
  input wire logic doubled_clock_mode_o,
  // Filter
  input wire logic rx_id_valid_i,
  input wire logic [28:0] rx_id_i,
  input wire logic rx_ext_i,
  input wire logic fwd_valid_o,
  input wire logic [28:0] fwd_id_o,
  input wire logic fwd_ext_o,
  input wire logic fwd_drop_o
);
  logic [1:0] jw;
  logic cm;
  logic [28:0] mt;
  logic [28:0] mk;
  logic wr;
  logic ok;
  logic [28:0] wid;
  // Completed writes and the expected filter verdict
  assign wr = psel_i & penable_i & pwrite_i & pready_o & ~pslverr_o;
  assign wid = rx_ext_i ? 29'h1FFFFFFF : 29'h00007FF;
  assign ok = (((rx_id_i ^ mt) & mk & wid) == 29'h0000000);
  // Shadow copies of the settings written over the bus
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      jw <= 2'h0;
      cm <= 1'b0;
      mt <= 29'h0000000;
      mk <= 29'h0000000;
    end else if (wr) begin
      if (paddr_i == 8'h04) jw <= pwdata_i[6:5];
      if (paddr_i == 8'h0C) cm <= pwdata_i[0];
      if (paddr_i == 8'h10) mt <= pwdata_i[28:0];
      if (paddr_i == 8'h14) mk <= pwdata_i[28:0];
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  property p_jump;
    resync_jump_width_o == jw;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump width output differs from written field");
  property p_mode;
    doubled_clock_mode_o == cm;
  endproperty
  a_mode: assert property (p_mode)
    else $error("clock mode output differs from written value");
  property p_unused;
    pready_o && !pwrite_i && paddr_i < 8'h0C |-> prdata_o[31:7] == 25'h0
      && (paddr_i == 8'h08 || !prdata_o[0])
      && (paddr_i != 8'h04 || !prdata_o[4]);
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused timing bit read as one");
  property p_accept;
    rx_id_valid_i && ok |=> fwd_valid_o && !fwd_drop_o;
  endproperty
  a_accept: assert property (p_accept)
    else $error("matching identifier not forwarded");
  property p_reject;
    rx_id_valid_i && !ok |=> fwd_drop_o && !fwd_valid_o;
  endproperty
  a_reject: assert property (p_reject)
    else $error("mismatching identifier forwarded");
  property p_open;
    rx_id_valid_i && mk == 29'h0000000 |=> fwd_valid_o;
  endproperty
  a_open: assert property (p_open)
    else $error("zero mask did not accept");
  property p_extid;
    rx_id_valid_i && rx_ext_i && ok |=>
      fwd_ext_o && fwd_id_o == $past(rx_id_i);
  endproperty
  a_extid: assert property (p_extid)
    else $error("extended identifier forwarded wrongly");
  property p_bitgap;
    bit_start_o |=> !bit_start_o [*3];
  endproperty
  a_bitgap: assert property (p_bitgap)
    else $error("bit shorter than four slices");
  property p_valchg;
    $changed(bit_value_o) |-> sample_pulse_o;
  endproperty
  a_valchg: assert property (p_valchg)
    else $error("bit value changed outside a sample");

  c_fwd: cover property (fwd_valid_o);
  c_drop: cover property (fwd_drop_o);
  c_err: cover property (pready_o && pslverr_o);
  c_smp: cover property (sample_pulse_o && bit_value_o);
endmodule

bind cbt_bit_timing cbt_bit_timing_asserts chk_u (.mclk_i, .resetn_i,
  .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .pready_o,
  .pslverr_o, .prdata_o, .sample_pulse_o, .bit_start_o, .bit_value_o,
  .resync_jump_width_o, .doubled_clock_mode_o, .rx_id_valid_i, .rx_id_i,
  .rx_ext_i, .fwd_valid_o, .fwd_id_o, .fwd_ext_o, .fwd_drop_o);

// *** tb/cbt_node_model.sv ***
// Another node on the shared bus, sending one level for each bit.
// Assumes bit boundaries from the block's bit start pulse.
`timescale 1ns/1ps
module cbt_node_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Bit boundary and level to send
  input wire logic bit_start_i,
  input wire logic level_i,
  // Bus line
  output logic can_rx_o
);
  // Recessive in reset, then a new level at each bit start
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      can_rx_o <= 1'b1;
    end else if (bit_start_i) begin
      can_rx_o <= level_i;
    end
  end
endmodule

// *** tb/tb.sv ***
// Self-checking bench of the bit timing and identifier filter block.
// Assumes the design, the checker and the node model are compiled.
`timescale 1ns/1ps
module tb;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic pready, pslverr, can_rx, tick, bstart, spulse, bval, dcm;
  logic [31:0] prdata;
  logic [1:0] rjw;
  logic rx_v = 1'b0;
  logic rx_ext = 1'b0;
  logic level = 1'b1;
  logic [28:0] rx_id = 29'h0000000;
  logic fv, fext, fdrop;
  logic [28:0] fid;
  logic [31:0] r, q, s;
  int err_count = 0;
  int compares = 0;
  int seed = 88;
  // 50 MHz clock
  always #10 mclk_i = ~mclk_i;

  cbt_bit_timing dut_u (.mclk_i, .resetn_i, .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata),
    .can_rx_i(can_rx), .slice_tick_o(tick), .bit_start_o(bstart),
    .sample_pulse_o(spulse), .bit_value_o(bval),
    .resync_jump_width_o(rjw), .doubled_clock_mode_o(dcm),
    .rx_id_valid_i(rx_v), .rx_id_i(rx_id), .rx_ext_i(rx_ext),
    .fwd_valid_o(fv), .fwd_id_o(fid), .fwd_ext_o(fext),
    .fwd_drop_o(fdrop));
  cbt_node_model node_u (.mclk_i, .resetn_i, .bit_start_i(bstart),
    .level_i(level), .can_rx_o(can_rx));

  task automatic give_verdict;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    err_count++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict();
  endtask
  // One bus transfer, held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    // Ready, data and error are taken at the rising edge that sees ready
    do begin
      @(posedge mclk_i);
      n++;
      if (n > 20) hang();
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
    // Let the stored value reach the outputs before any check
    @(negedge mclk_i);
  endtask
  // Expected verdict of the acceptance check
  function automatic logic exp_acc(input logic [28:0] id, input logic ext,
      input logic [28:0] m, input logic [28:0] k);
    logic [28:0] w;
    w = ext ? 29'h1FFFFFFF : 29'h00007FF;
    exp_acc = (((id ^ m) & k & w) == 29'h0000000);
  endfunction
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] g;
    logic e;
    apb(1'b0, a, 32'h00000000, g, e);
    check(g, x);
    check({31'h0, e}, {31'h0, xe});
  endtask
  task automatic wait_bs;
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
      if (n > 5000) hang();
    end while (bstart !== 1'b1);
  endtask
  // Program timing, then measure one whole bit
  task automatic timing(input logic [5:0] b, input logic [2:0] p,
      input logic [2:0] s1, input logic [2:0] s2, input logic m,
      input logic lv);
    int c, sa, t1, t2;
    wr(8'h00, {25'h0, b, 1'b0});
    wr(8'h04, {28'h0, p, 1'b0});
    wr(8'h08, {24'h0, 1'b0, s2, s1, m});
    level <= lv;
    wait_bs();
    wait_bs();
    c = 0;
    sa = -1;
    t1 = -1;
    t2 = -1;
    do begin
      @(negedge mclk_i);
      c++;
      if (spulse === 1'b1) sa = c;
      if (tick === 1'b1 && t1 >= 0 && t2 < 0) t2 = c;
      if (tick === 1'b1 && t1 < 0) t1 = c;
      if (c > 5000) hang();
    end while (bstart !== 1'b1);
    check(c, (4 + p + s1 + s2) * (b + 1));
    check(sa, (3 + p + s1) * (b + 1));
    check(t1, b + 1);
    check(t2 - t1, b + 1);
    check({31'h0, bval}, {31'h0, lv});
  endtask
  // Present one identifier and compare the verdict
  task automatic filt(input logic [28:0] id, input logic ext,
      input logic [28:0] m, input logic [28:0] k);
    logic [28:0] w;
    logic acc;
    wr(8'h10, {3'h0, m});
    wr(8'h14, {3'h0, k});
    w = ext ? 29'h1FFFFFFF : 29'h00007FF;
    acc = exp_acc(id, ext, m, k);
    @(posedge mclk_i);
    rx_v <= 1'b1;
    rx_id <= id;
    rx_ext <= ext;
    @(posedge mclk_i);
    rx_v <= 1'b0;
    #1;
    check({31'h0, fv}, {31'h0, acc});
    check({31'h0, fdrop}, {31'h0, ~acc});
    if (acc) check({2'h0, fext, fid & w}, {2'h0, ext, id & w});
  endtask

  initial begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd(8'h00, 32'h00000000, 1'b0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h0000007E, 1'b0);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h0000006E, 1'b0);
    check({30'h0, rjw}, 32'h00000003);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h0000007F, 1'b0);
    rd(8'h1C, 32'h00000000, 1'b1);
    wr(8'h0C, 32'h00000001);
    check({31'h0, dcm}, 32'h00000001);
    wr(8'h0C, 32'h00000000);
    check({31'h0, dcm}, 32'h00000000);
    timing(6'h00, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0);
    timing(6'h3F, 3'h7, 3'h7, 3'h7, 1'b1, 1'b0);
    // Faster bus rate: doubled clock, 500 clocks per bit as 20 x 25
    wr(8'h0C, 32'h00000001);
    timing(6'h18, 3'h2, 3'h7, 3'h7, 1'b0, 1'b1);
    repeat (5) begin
      r = $random(seed);
      timing({3'h0, r[2:0]}, r[5:3], r[8:6], r[11:9], r[12], r[13]);
    end
    filt(29'h123, 1'b0, 29'h123, 29'h7FF);
    filt(29'h124, 1'b0, 29'h123, 29'h7FF);
    filt(29'h13F, 1'b0, 29'h100, 29'h7C0);
    filt(29'h140, 1'b0, 29'h100, 29'h7C0);
    filt(29'h1F800123, 1'b0, 29'h123, 29'h1FFFFFFF);
    filt(29'h0ABCDEF1, 1'b1, 29'h1555AAAA, 29'h0);
    repeat (20) begin
      r = $random(seed);
      q = $random(seed);
      s = $random(seed);
      filt(r[28:0] ^ (q[28:0] & s[28:0] & {29{s[30]}}), s[31], r[28:0],
        q[28:0] & {29{s[29]}});
    end
    give_verdict();
  end
endmodule
